// ### pkg/ccst_defines.svh
`ifndef CCST_DEFINES_SVH
`define CCST_DEFINES_SVH

// lane count and field widths
`define CCST_LANES 8
`define CCST_CODE_W 4
`define CCST_HEAD_W 3
`define CCST_APPS 16

// byte offsets of the packed result bytes
`define CCST_OFS_LANES_1_2 8'hca
`define CCST_OFS_LANES_3_4 8'hcb
`define CCST_OFS_LANES_5_6 8'hcc
`define CCST_OFS_LANES_7_8 8'hcd
`define CCST_RD_IDLE 8'h00

// field positions inside a result byte
`define CCST_EVEN_HI 7
`define CCST_EVEN_LO 4
`define CCST_ODD_HI 3
`define CCST_ODD_LO 0

// result codes
`define CCST_CODE_NO_INFO 4'h0
`define CCST_CODE_COMPLETED_OK 4'h1
`define CCST_CODE_GENERIC_REFUSAL 4'h2
`define CCST_CODE_BAD_APPLICATION_SELECT 4'h3
`define CCST_CODE_BAD_LANE_SET 4'h4
`define CCST_CODE_BAD_SIGNAL_INTEGRITY 4'h5
`define CCST_CODE_LANES_BUSY 4'h6
`define CCST_CODE_PARTIAL_LANE_GROUP 4'h7
`define CCST_CODE_BUSY_PROCESSING 4'hc
`define CCST_CODE_CUSTOM_REFUSAL 4'hd

// reserved band that a field must never show
`define CCST_CODE_RSVD_LO 4'h8
`define CCST_CODE_RSVD_HI 4'hb

`endif

// ### pkg/ccst_pkg.sv
`include "ccst_defines.svh"

package ccst_pkg;
    typedef logic [`CCST_CODE_W-1:0] ccst_code_t;
    typedef logic [`CCST_HEAD_W-1:0] ccst_head_t;
    typedef logic [`CCST_LANES-1:0] ccst_mask_t;
    typedef enum logic {CCST_EX_IDLE, CCST_EX_RUN} ccst_exec_e;
endpackage

// ### pkg/ccst_status_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccst_defines.svh"

// carries lane result writes into the store and the stored codes back
interface ccst_status_if;
    import ccst_pkg::*;
    ccst_mask_t wrEn;
    ccst_code_t [`CCST_LANES-1:0] wrCode;
    ccst_code_t [`CCST_LANES-1:0] code;
    modport writer (output wrEn, output wrCode, input code);
    modport store (input wrEn, input wrCode, output code);
endinterface

`default_nettype wire

// ### hw/ccst_status_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccst_defines.svh"

module ccst_status_store
    import ccst_pkg::*;
(
    input wire logic mclk, // module clock
    input wire logic rst_n, // async reset, active low
    ccst_status_if.store st, // lane result writes and codes
    input wire logic [7:0] rdAddr, // byte address being read
    output logic [7:0] rdByte // packed byte at rdAddr, zero if unmapped
);
    ccst_code_t [`CCST_LANES-1:0] code_q;
    ccst_code_t [`CCST_LANES-1:0] code_d;
    logic [7:0] byte12;
    logic [7:0] byte34;
    logic [7:0] byte56;
    logic [7:0] byte78;

    // each lane field takes its write, otherwise holds
    always_comb
    begin
        for (int i = 0; i < `CCST_LANES; i++)
        begin
            code_d[i] = st.wrEn[i] ? st.wrCode[i] : code_q[i];
        end
    end

    // fields start empty until a command is taken
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            code_q <= '{default: `CCST_CODE_NO_INFO};
        else
            code_q <= code_d;
    end

    assign st.code = code_q;

    // even lane (numbered from one) in the upper nibble
    assign byte12 = {code_q[1], code_q[0]};
    assign byte34 = {code_q[3], code_q[2]};
    assign byte56 = {code_q[5], code_q[4]};
    assign byte78 = {code_q[7], code_q[6]};

    // read only; unmapped bytes answer zero
    assign rdByte = (rdAddr == `CCST_OFS_LANES_1_2) ? byte12 :
                    (rdAddr == `CCST_OFS_LANES_3_4) ? byte34 :
                    (rdAddr == `CCST_OFS_LANES_5_6) ? byte56 :
                    (rdAddr == `CCST_OFS_LANES_7_8) ? byte78 : `CCST_RD_IDLE;
endmodule

`default_nettype wire

// ### hw/ccst_group_eval.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccst_defines.svh"

module ccst_group_eval
    import ccst_pkg::*;
#(
    parameter int unsigned HEAD = 0 // lane index that heads this group
)
(
    input wire logic [`CCST_LANES-1:0] trig, // triggered lanes
    input wire logic [`CCST_LANES*`CCST_HEAD_W-1:0] firstLane, // head per lane
    input wire logic [`CCST_LANES*`CCST_CODE_W-1:0] application_select_code, // app code per lane
    input wire logic [`CCST_LANES-1:0] busy, // lanes showing busy code
    input wire logic immediate, // hot signal integrity trigger
    input wire logic [`CCST_LANES-1:0] activeSt, // lanes in path_active_state
    input wire logic [`CCST_LANES-1:0] readySt, // lanes in path_ready_state
    input wire logic [`CCST_APPS-1:0] appSupported, // usable app codes
    input wire logic [`CCST_LANES-1:0] siInvalid, // bad signal integrity set
    input wire logic [`CCST_LANES-1:0] customReject, // private refusal
    output logic [`CCST_LANES-1:0] grpMask, // lanes of this group
    output logic accept, // group triggered and idle
    output logic [`CCST_CODE_W-1:0] code // validation outcome
);
    localparam ccst_head_t HEAD_ID = HEAD[`CCST_HEAD_W-1:0];
    logic [`CCST_LANES-1:0] appDiff;
    logic [`CCST_CODE_W-1:0] headApp;
    logic [`CCST_LANES-1:0] onLanes;
    logic hit;
    logic partial;
    logic hotOk;
    logic notOff;

    assign headApp = application_select_code[HEAD*`CCST_CODE_W +: `CCST_CODE_W];

    // group membership from the staged head index
    for (genvar j = 0; j < `CCST_LANES; j++)
    begin : g_lane
        assign grpMask[j] = firstLane[j*`CCST_HEAD_W +: `CCST_HEAD_W] == HEAD_ID;
        assign appDiff[j] = application_select_code[j*`CCST_CODE_W +: `CCST_CODE_W] != headApp;
    end

    assign onLanes = activeSt | readySt;
    assign hit = |(grpMask & trig);
    assign accept = hit && !(|(grpMask & busy));
    assign partial = (grpMask & trig) != grpMask;
    assign hotOk = immediate && ((grpMask & ~onLanes) == '0);
    assign notOff = |(grpMask & onLanes);

    // the first failing check in this order wins; later checks are masked
    assign code = (headApp == `CCST_CODE_NO_INFO) ? `CCST_CODE_BAD_APPLICATION_SELECT :
                  !appSupported[headApp] ? `CCST_CODE_BAD_APPLICATION_SELECT :
                  !grpMask[HEAD] ? `CCST_CODE_GENERIC_REFUSAL :
                  |(grpMask & appDiff) ? `CCST_CODE_BAD_LANE_SET :
                  (partial && !hotOk) ? `CCST_CODE_PARTIAL_LANE_GROUP :
                  (!immediate && notOff) ? `CCST_CODE_LANES_BUSY :
                  |(grpMask & siInvalid) ? `CCST_CODE_BAD_SIGNAL_INTEGRITY :
                  |(grpMask & customReject) ? `CCST_CODE_CUSTOM_REFUSAL :
                  `CCST_CODE_COMPLETED_OK;
endmodule

`default_nettype wire

// ### hw/ccst_config_tracker.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccst_defines.svh"

module ccst_config_tracker
    import ccst_pkg::*;
(
    input wire logic mclk, // module clock, 10 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic applyWr, // one-cycle write of an apply register
    input wire logic [`CCST_LANES-1:0] applyMask, // lane trigger mask written
    input wire logic immediateTrigger, // write was an immediate_trigger
    input wire logic [`CCST_LANES*`CCST_CODE_W-1:0] stagedAppSel, // per lane
    input wire logic [`CCST_LANES*`CCST_HEAD_W-1:0] stagedFirstLane, // per lane
    input wire logic [`CCST_APPS-1:0] appSupported, // usable app codes
    input wire logic [`CCST_LANES-1:0] siInvalid, // staged SI not usable
    input wire logic [`CCST_LANES-1:0] customReject, // private refusal
    input wire logic [`CCST_LANES-1:0] pathActiveState, // lane path active
    input wire logic [`CCST_LANES-1:0] pathReadyState, // lane path ready
    input wire logic regRd, // one-cycle read strobe
    input wire logic [7:0] regAddr, // byte address of the read
    output logic [7:0] regRdData, // read byte, valid cycle after regRd
    output logic execStart, // one-cycle start of the execution engine
    output logic [`CCST_LANES-1:0] execLanes, // lanes being executed
    output logic execImmediate, // execution is a hot SI update
    input wire logic execDone, // one-cycle end of execution
    output logic [`CCST_LANES-1:0] busyLanes // private busy view
);
    ccst_status_if st ();

    // acceptance stage
    logic [`CCST_LANES-1:0] busy;
    logic [`CCST_LANES-1:0] grpMask [`CCST_LANES];
    logic [`CCST_LANES-1:0] grpAccept;
    ccst_code_t [`CCST_LANES-1:0] grpCode;
    ccst_code_t [`CCST_LANES-1:0] laneCode;
    logic [`CCST_LANES-1:0] accepted;

    // validation stage
    logic [`CCST_LANES-1:0] valLanes_q;
    ccst_code_t [`CCST_LANES-1:0] valCode_q;
    logic valImm_q;
    logic [`CCST_LANES-1:0] okLanes;
    logic [`CCST_LANES-1:0] rejLanes;
    logic [`CCST_LANES-1:0] codeUnfit;
    ccst_code_t [`CCST_LANES-1:0] refusalCode;

    // execution stage
    ccst_exec_e exState_q;
    ccst_exec_e exState_d;
    logic [`CCST_LANES-1:0] pend_q;
    logic [`CCST_LANES-1:0] pend_d;
    logic [`CCST_LANES-1:0] pendImm_q;
    logic [`CCST_LANES-1:0] pendImm_d;
    logic [`CCST_LANES-1:0] execLanes_q;
    logic [`CCST_LANES-1:0] execLanes_d;
    logic execImm_q;
    logic execImm_d;
    logic execStart_q;
    logic startNow;
    logic takeImm;
    logic [`CCST_LANES-1:0] take;
    logic [`CCST_LANES-1:0] doneLanes;

    // read port
    logic [7:0] rdByte;
    logic [7:0] regRdData_q;

    // busy lanes are those whose field shows the busy code
    for (genvar i = 0; i < `CCST_LANES; i++)
    begin : g_busy
        assign busy[i] = st.code[i] == `CCST_CODE_BUSY_PROCESSING;
    end

    // spare apply bits mirror this; the host still polls the fields
    assign busyLanes = busy;

    // one evaluator per possible group head
    for (genvar g = 0; g < `CCST_LANES; g++)
    begin : g_grp
        ccst_group_eval #(
            .HEAD(g)
        ) u_eval (
            .trig(applyMask),
            .firstLane(stagedFirstLane),
            .application_select_code(stagedAppSel),
            .busy(busy),
            .immediate(immediateTrigger),
            .activeSt(pathActiveState),
            .readySt(pathReadyState),
            .appSupported(appSupported),
            .siInvalid(siInvalid),
            .customReject(customReject),
            .grpMask(grpMask[g]),
            .accept(grpAccept[g]),
            .code(grpCode[g])
        );
    end

    // every lane takes the verdict of its own group head
    for (genvar j = 0; j < `CCST_LANES; j++)
    begin : g_code
        assign laneCode[j] =
            grpCode[stagedFirstLane[j*`CCST_HEAD_W +: `CCST_HEAD_W]];
    end

    // union of the groups that pass the idle check; others are dropped
    always_comb
    begin
        accepted = '0;
        for (int g = 0; g < `CCST_LANES; g++)
        begin
            if (applyWr && grpAccept[g])
                accepted = accepted | grpMask[g];
        end
    end

    // validation outcome is held one cycle so phases stay ordered
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valLanes_q <= '0;
            valCode_q <= '{default: `CCST_CODE_NO_INFO};
            valImm_q <= 1'b0;
        end
        else
        begin
            valLanes_q <= accepted;
            valCode_q <= laneCode;
            valImm_q <= immediateTrigger;
        end
    end

    // refused lanes skip execution and report straight away
    for (genvar j = 0; j < `CCST_LANES; j++)
    begin : g_split
        assign rejLanes[j] =
            valLanes_q[j] && (valCode_q[j] != `CCST_CODE_COMPLETED_OK);
        assign okLanes[j] =
            valLanes_q[j] && (valCode_q[j] == `CCST_CODE_COMPLETED_OK);
    end

    // a none, busy or reserved code is turned into a generic refusal; such a stray
    // code from a validator would hide the result or leave the path locked busy
    for (genvar j = 0; j < `CCST_LANES; j++)
    begin : g_guard
        assign codeUnfit[j] =
            (valCode_q[j] == `CCST_CODE_NO_INFO) ||
            (valCode_q[j] == `CCST_CODE_BUSY_PROCESSING) ||
            ((valCode_q[j] >= `CCST_CODE_RSVD_LO) && (valCode_q[j] <= `CCST_CODE_RSVD_HI));
        assign refusalCode[j] =
            codeUnfit[j] ? `CCST_CODE_GENERIC_REFUSAL : valCode_q[j];
    end

    // immediate work runs first so hot SI updates are not held back
    assign startNow = (exState_q == CCST_EX_IDLE) && (pend_q != '0);
    assign takeImm = |(pend_q & pendImm_q);
    assign take = startNow ? (pend_q & (takeImm ? pendImm_q : ~pendImm_q)) : '0;
    assign doneLanes = ((exState_q == CCST_EX_RUN) && execDone) ? execLanes_q : '0;

    // validated lanes queue for the engine; a lane re-validated as non-immediate
    // drops its old immediate mark so it cannot jump ahead of older work
    always_comb
    begin
        pend_d = (pend_q & ~take) | okLanes;
        pendImm_d = (pendImm_q & ~take) | (valImm_q ? okLanes : '0);
        pendImm_d = pendImm_d & ~(okLanes & {`CCST_LANES{~valImm_q}});
    end

    // one batch runs at a time; the next starts only after done
    always_comb
    begin
        execLanes_d = execLanes_q;
        execImm_d = execImm_q;
        exState_d = exState_q;
        unique case (exState_q)
            CCST_EX_IDLE:
            begin
                if (startNow)
                begin
                    execLanes_d = take;
                    execImm_d = takeImm;
                    exState_d = CCST_EX_RUN;
                end
            end
            CCST_EX_RUN:
            begin
                if (execDone)
                    exState_d = CCST_EX_IDLE;
            end
        endcase
    end

    // execution engine registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exState_q <= CCST_EX_IDLE;
            pend_q <= '0;
            pendImm_q <= '0;
            execLanes_q <= '0;
            execImm_q <= 1'b0;
            execStart_q <= 1'b0;
        end
        else
        begin
            exState_q <= exState_d;
            pend_q <= pend_d;
            pendImm_q <= pendImm_d;
            execLanes_q <= execLanes_d;
            execImm_q <= execImm_d;
            execStart_q <= startNow;
        end
    end

    assign execStart = execStart_q;
    assign execLanes = execLanes_q;
    assign execImmediate = execImm_q;

    // busy marking, refusal and success touch disjoint lanes by construction,
    // since a busy lane can never be accepted again
    assign st.wrEn = accepted | rejLanes | doneLanes;
    for (genvar j = 0; j < `CCST_LANES; j++)
    begin : g_wr
        assign st.wrCode[j] =
            accepted[j] ? `CCST_CODE_BUSY_PROCESSING :
            rejLanes[j] ? refusalCode[j] :
            `CCST_CODE_COMPLETED_OK;
    end

    // packed read-only result bytes
    ccst_status_store u_store (
        .mclk(mclk),
        .rst_n(rst_n),
        .st(st),
        .rdAddr(regAddr),
        .rdByte(rdByte)
    );

    // read data is registered and holds until the next read
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            regRdData_q <= `CCST_RD_IDLE;
        else if (regRd)
            regRdData_q <= rdByte;
    end

    assign regRdData = regRdData_q;
endmodule

`default_nettype wire

// ### verification/ccst_config_tracker_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccst_defines.svh"

module ccst_config_tracker_properties (
    input wire logic mclk, // module clock
    input wire logic rst_n, // async reset, active low
    input wire logic applyWr, // apply write strobe
    input wire logic [`CCST_LANES-1:0] applyMask, // trigger mask
    input wire logic regRd, // read strobe
    input wire logic [7:0] regAddr, // read address
    input wire logic [7:0] regRdData, // read byte
    input wire logic execStart, // execution start
    input wire logic [`CCST_LANES-1:0] execLanes, // executed lanes
    input wire logic execDone, // execution end
    input wire logic [`CCST_LANES-1:0] busyLanes // busy view
);
    logic [7:0] rdOfs;
    logic inRange;
    logic [1:0] pairBusy;

    // which lane pair a read covers; its busy bits predict the nibbles
    assign rdOfs = regAddr - `CCST_OFS_LANES_1_2;
    assign inRange = rdOfs < 8'h04;
    assign pairBusy = busyLanes[{rdOfs[1:0], 1'b0} +: 2];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_start_lanes_busy: assert property (execStart |-> execLanes != 8'h00
        && (execLanes & ~busyLanes) == 8'h00) else $error("exec lanes not busy");
    chk_start_after_accept: assert property (execStart |->
        (execLanes & ~$past(busyLanes)) == 8'h00) else $error("exec before acceptance");
    chk_start_one_pulse: assert property (execStart |=> !execStart)
        else $error("exec start too long");
    chk_busy_needs_apply: assert property ((busyLanes & ~$past(busyLanes)) != 8'h00
        |-> $past(applyWr) && ($past(applyMask) & busyLanes) != 8'h00)
        else $error("busy without trigger");
    chk_busy_clear_cause: assert property ((~busyLanes & $past(busyLanes)) != 8'h00
        |-> $past(execDone) || ($past(busyLanes) & ~$past(busyLanes, 2)) != 8'h00)
        else $error("busy cleared without result");
    chk_read_busy_nibble: assert property (regRd && inRange |=>
        ((regRdData[3:0] == 4'hc) == $past(pairBusy[0]))
        && ((regRdData[7:4] == 4'hc) == $past(pairBusy[1]))) else $error("busy nibble wrong");
    chk_unmapped_zero: assert property (regRd && !inRange |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_no_reserved_code: assert property (regRd && inRange |=>
        regRdData[3:2] != 2'b10 && regRdData[7:6] != 2'b10
        && regRdData[3:1] != 3'b111 && regRdData[7:5] != 3'b111) else $error("unused code");
    chk_reset_clear: assert property ($rose(rst_n) |-> busyLanes == 8'h00
        && regRdData == 8'h00 && !execStart) else $error("reset state wrong");
endmodule

bind ccst_config_tracker ccst_config_tracker_properties props (.mclk(mclk), .rst_n(rst_n),
    .applyWr(applyWr), .applyMask(applyMask), .regRd(regRd), .regAddr(regAddr),
    .regRdData(regRdData), .execStart(execStart), .execLanes(execLanes),
    .execDone(execDone), .busyLanes(busyLanes));

`default_nettype wire

// ### verification/ccst_exec_model.sv
`timescale 1ns/10ps
`default_nettype none

module ccst_exec_model (
    input wire logic mclk, // module clock
    input wire logic rst_n, // async reset, active low
    input wire logic execStart, // batch start from the tracker
    input wire logic [4:0] lag, // wait before done, 0 is prompt
    output logic execDone // one-cycle end of a batch
);
    logic [5:0] cnt_q;

    // a validated batch never fails, so done always follows a start
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 6'h00;
            execDone <= 1'b0;
        end
        else
        begin
            execDone <= (cnt_q == 6'h01);
            if (execStart)
                cnt_q <= {1'b0, lag} + 6'h01;
            else if (cnt_q != 6'h00)
                cnt_q <= cnt_q - 6'h01;
        end
    end
endmodule

`default_nettype wire

// ### verification/ccst_config_tracker_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccst_defines.svh"

module ccst_config_tracker_tb;
    import ccst_pkg::*;
    logic mclk, rst_n, applyWr, immediateTrigger, regRd, execStart, execImmediate, execDone;
    logic [7:0] applyMask, regAddr, regRdData, siInvalid, customReject, execLanes, busyLanes;
    logic [7:0] pathActiveState, pathReadyState, m, grp, d;
    logic [31:0] stagedAppSel;
    logic [23:0] stagedFirstLane;
    logic [15:0] appSupported;
    logic [4:0] lag;
    ccst_code_t e;
    logic [8:0] lastRun;
    integer seed, badCount, nChecks, nStarts, s0, g, k, it, n;

    ccst_config_tracker dut (.mclk(mclk), .rst_n(rst_n), .applyWr(applyWr),
        .applyMask(applyMask), .immediateTrigger(immediateTrigger),
        .stagedAppSel(stagedAppSel), .stagedFirstLane(stagedFirstLane),
        .appSupported(appSupported), .siInvalid(siInvalid), .customReject(customReject),
        .pathActiveState(pathActiveState), .pathReadyState(pathReadyState), .regRd(regRd),
        .regAddr(regAddr), .regRdData(regRdData), .execStart(execStart),
        .execLanes(execLanes), .execImmediate(execImmediate), .execDone(execDone),
        .busyLanes(busyLanes));
    ccst_exec_model engine (.mclk(mclk), .rst_n(rst_n), .execStart(execStart), .lag(lag),
        .execDone(execDone));

    // 100 ns clock; starts are counted and the batch kept, to tell executed commands apart
    always #50 mclk = ~mclk;
    always @(posedge mclk)
        if (execStart === 1'b1)
        begin
            nStarts <= nStarts + 1;
            lastRun <= {execImmediate, execLanes};
        end

    task automatic printVerdict;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // register bytes and the busy view
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // what reaches the execution engine: a start count or {immediate, lanes}
    task automatic chk_exec(input logic [8:0] got, input logic [8:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("BAD %0t engine got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge mclk);
        regRd = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRd = 1'b0;
        q = regRdData;
    endtask

    // trigger, then read the pair in the very next cycle, before any result lands
    task automatic cmd(input logic [7:0] mk, input logic [7:0] gm, input logic [7:0] a);
        @(negedge mclk);
        applyWr = 1'b1;
        applyMask = mk;
        @(negedge mclk);
        applyWr = 1'b0;
        regRd = 1'b1;
        regAddr = a;
        chk(busyLanes, gm);
        @(negedge mclk);
        regRd = 1'b0;
        chk(regRdData, 8'hcc);
    endtask

    task automatic set_defaults;
        applyWr = 1'b0;
        applyMask = 8'h00;
        immediateTrigger = 1'b0;
        stagedAppSel = 32'h11111111;
        stagedFirstLane = 24'hda4480; // lanes grouped in pairs, head is the even lane
        siInvalid = 8'h00;
        customReject = 8'h00;
        pathActiveState = 8'h00;
        pathReadyState = 8'h00;
    endtask

    // each fault kind plants exactly one refusal reason
    function automatic ccst_code_t exp_code(input integer kind);
        case (kind)
            1: return `CCST_CODE_BAD_APPLICATION_SELECT;
            2: return `CCST_CODE_GENERIC_REFUSAL;
            3: return `CCST_CODE_BAD_LANE_SET;
            4: return `CCST_CODE_PARTIAL_LANE_GROUP;
            5: return `CCST_CODE_LANES_BUSY;
            6: return `CCST_CODE_BAD_SIGNAL_INTEGRITY;
            7: return `CCST_CODE_CUSTOM_REFUSAL;
            default: return `CCST_CODE_COMPLETED_OK;
        endcase
    endfunction

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        seed = 28;
        badCount = 0;
        nChecks = 0;
        nStarts = 0;
        regRd = 1'b0;
        regAddr = 8'h00;
        lag = 5'h00;
        appSupported = 16'h0002;
        set_defaults();
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        for (n = 0; n < 6; n++)
        begin
            rd(8'hc9 + n[7:0], d);
            chk(d, 8'h00);
        end
        for (it = 0; it < 150; it++)
        begin
            g = {$random(seed)} % 4;
            k = {$random(seed)} % 9;
            lag = 5'($random(seed));
            appSupported = 16'($random(seed)) | 16'h0002;
            grp = 8'h03 << (2 * g);
            m = grp;
            case (k)
                1: appSupported[1] = 1'b0;
                2: stagedFirstLane[6 * g +: 6] = {3'(2 * g), 3'(2 * g + 1)};
                3: stagedAppSel[8 * g + 4 +: 4] = 4'h2;
                4: m = 8'h01 << (2 * g + it % 2);
                5: pathActiveState[2 * g] = 1'b1;
                6: siInvalid[2 * g + 1] = 1'b1;
                7: customReject[2 * g] = 1'b1;
                8:
                begin
                    m = 8'h01 << (2 * g + it % 2);
                    immediateTrigger = 1'b1;
                    pathActiveState[2 * g] = 1'b1;
                    pathReadyState[2 * g + 1] = 1'b1;
                end
                default: m = grp;
            endcase
            s0 = nStarts;
            cmd(m, grp, 8'hca + g[7:0]);
            if (k == 0)
            begin
                siInvalid = 8'hff;
                cmd(grp, grp, 8'hca + g[7:0]);
                siInvalid = 8'h00;
            end
            d = 8'hcc;
            for (n = 0; n < 60 && d === 8'hcc; n++) rd(8'hca + g[7:0], d);
            if (d === 8'hcc)
            begin
                badCount++;
                $display("BAD %0t no result reported", $time);
                break;
            end
            e = exp_code(k);
            chk(d, {e, e});
            chk_exec(9'(nStarts - s0), (k == 0 || k == 8) ? 9'h001 : 9'h000);
            if (k == 0 || k == 8)
                chk_exec(lastRun, {k == 8, grp});
            rd(8'hce - g[7:0] * 8'h05, d);
            chk(d, 8'h00);
            set_defaults();
        end
        printVerdict();
    end
endmodule

`default_nettype wire
